// file: stc_timer.sv
// stc_timer: system time clock counter, preload, compare and APB register file
//
// Functional notes
// [R1] writing either preload register reloads the whole counter, base and extension
// [R2] preload high holds extension in bits 9..1, base top in bit 0, reset zero
// [R3] software clears compare enable before writing preload high
// [R4] software loads preload on first clock reference and on each discontinuity
// [R5] value low reads the live low 32 base bits, normally advancing at 90 kHz
// [R6] software may read value low twice to get a trustworthy value
// [R7] value low bits 31..0 carry the low 32 base bits
// [R8] value high carries running extension in bits 9..1, base top in bit 0
// [R9] extension read coherency is not guaranteed
// [R10] enabled masked compare match sets the time match flag in status
// [R11] compare low holds low 32 compare bits, read/write, reset zero
// [R12] compare high bit 0 holds compare top bit, read/write, reset zero
// [R13] software clears compare enable before writing compare registers
// [R14] unused upper bits of high registers read zero, writes ignored
// [R15] set mask bits exclude their compare bits from the match
// [R16] 90 kHz mode: base steps when extension wraps 299 to 0; else every tick
// [R17] preload low supplies the low 32 base bits
// [R18] with time clock disabled the counters hold
// [R19] compare checked on every counter update, flag set per matching update
// [R20] preload applies on the next edge, overriding that cycle's increment
`timescale 1ns/1ps
`default_nettype none
module stc_timer
   import stc_pkg::*;
(
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   // apb slave
   input  wire logic [STC_ADDR_W-1:0] paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [STC_DATA_W-1:0] pwdata,
   input  wire logic [3:0]            pstrb,
   output logic [STC_DATA_W-1:0]      prdata,
   output logic                       pready,
   output logic                       pslverr,
   // time clock pin and status
   input  wire logic                  time_clock_input,
   output logic                       time_match_flag
);

   logic [STC_BASE_W-1:0] base_reg;
   logic [STC_EXT_W-1:0]  ext_reg;
   logic [31:0]           pre_low_reg;
   logic [STC_EXT_W-1:0]  pre_ext_reg;
   logic                  pre_top_reg;
   logic [31:0]           cmp_low_reg;
   logic                  cmp_top_reg;
   logic [31:0]           msk_low_reg;
   logic                  msk_top_reg;
   logic                  enable_reg;
   logic                  irq_en_reg;
   stc_rate_t             rate_reg;
   logic                  load_pend_reg;
   logic                  updated_reg;
   logic                  flag_reg;
   logic [31:0]           prdata_reg;
   logic                  pslverr_reg;
   logic                  tick;
   logic                  match;
   logic                  match_event;
   logic                  wr_access;
   logic                  rd_setup;
   logic                  ext_wrap;
   logic                  advance;
   logic [31:0]           wr_word;
   logic [31:0]           rd_word;
   logic                  rd_hit;

   function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return res;
   endfunction

   stc_edge_sync u_edge (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .pin_in     (time_clock_input),
      .rise_pulse (tick)
   );

   stc_masked_match u_match (
      .count_base   (base_reg),
      .compare_time ({cmp_top_reg, cmp_low_reg}),
      .compare_mask ({msk_top_reg, msk_low_reg}),
      .match        (match)
   );

   // zero wait states: every transfer ends in its first access cycle
   assign pready    = 1'b1;
   assign wr_access = psel & penable & pwrite;
   assign rd_setup  = psel & ~penable;
   assign prdata    = prdata_reg;
   assign pslverr   = pslverr_reg;
   assign time_match_flag = flag_reg;

   // control, preload, compare and mask registers
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         enable_reg  <= STC_BIT_RST;
         irq_en_reg  <= STC_BIT_RST;
         rate_reg    <= STC_RATE_90K;
         pre_low_reg <= STC_WORD_RST;
         pre_ext_reg <= STC_EXT_RST;
         pre_top_reg <= STC_BIT_RST;
         cmp_low_reg <= STC_WORD_RST;
         cmp_top_reg <= STC_BIT_RST;
         msk_low_reg <= STC_WORD_RST;
         msk_top_reg <= STC_BIT_RST;
      end
      else if (wr_access)
      begin
         case (paddr)
            STC_CTRL_OFS:
            begin
               if (pstrb[0])
               begin
                  irq_en_reg <= pwdata[CTRL_IRQ_EN_BIT];
                  enable_reg <= pwdata[CTRL_ENABLE_BIT];
                  rate_reg   <= stc_rate_t'(pwdata[CTRL_RATE_BIT]);
               end
            end
            STC_PRE_LOW_OFS:
               pre_low_reg <= apply_strb(pre_low_reg, pwdata, pstrb); // [R17]
            STC_PRE_HIGH_OFS:
            begin
               // upper bits are not stored, so writes to them vanish
               pre_ext_reg <= wr_word[HIGH_EXT_MSB:HIGH_EXT_LSB]; // [R2] [R14]
               pre_top_reg <= wr_word[HIGH_TOP_BIT]; // [R2]
            end
            STC_CMP_LOW_OFS:
               cmp_low_reg <= apply_strb(cmp_low_reg, pwdata, pstrb); // [R11]
            STC_CMP_HIGH_OFS:
               if (pstrb[0])
                  cmp_top_reg <= pwdata[HIGH_TOP_BIT]; // [R12] [R14]
            STC_MSK_LOW_OFS:
               msk_low_reg <= apply_strb(msk_low_reg, pwdata, pstrb);
            STC_MSK_HIGH_OFS:
               if (pstrb[0])
                  msk_top_reg <= pwdata[HIGH_TOP_BIT];
            default:
               ;
         endcase
      end
   end

   // merged word for the preload high register only
   assign wr_word = apply_strb({22'h000000, pre_ext_reg, pre_top_reg}, pwdata, pstrb);

   // preload lands one cycle after the write
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         load_pend_reg <= 1'b0;
      else
         load_pend_reg <= wr_access & ((paddr == STC_PRE_LOW_OFS) | (paddr == STC_PRE_HIGH_OFS)); // [R1]
   end

   assign advance  = enable_reg & tick; // [R18]
   assign ext_wrap = (ext_reg >= STC_EXT_LAST);

   // running counter; a preload beats the increment of the same cycle
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         base_reg <= STC_BASE_RST;
         ext_reg  <= STC_EXT_RST;
      end
      else if (load_pend_reg)
      begin
         base_reg <= {pre_top_reg, pre_low_reg}; // [R1] [R17] [R20]
         ext_reg  <= pre_ext_reg; // [R1]
      end
      else if (advance)
      begin
         // an extension preloaded above the wrap point wraps at once
         ext_reg <= ext_wrap ? STC_EXT_RST : ext_reg + 9'h001; // [R16]
         if (rate_reg == STC_RATE_TICK || ext_wrap)
            base_reg <= base_reg + 33'h0_0000_0001; // [R16]
      end
   end

   // the compare looks at the counter once after each change
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         updated_reg <= 1'b0;
      else
         updated_reg <= load_pend_reg | advance; // [R19]
   end

   assign match_event = irq_en_reg & updated_reg & match; // [R10] [R19]

   // sticky match flag, write one to clear; a new match beats the clear
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         flag_reg <= STC_BIT_RST;
      else if (match_event)
         flag_reg <= 1'b1; // [R10]
      else if (wr_access && paddr == STC_STATUS_OFS && pstrb[0] && pwdata[STAT_MATCH_BIT])
         flag_reg <= 1'b0;
   end

   // read decode; extension is sampled as is, no coherency latch
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (paddr)
         STC_CTRL_OFS:
         begin
            rd_word[CTRL_RATE_BIT]   = rate_reg;
            rd_word[CTRL_IRQ_EN_BIT] = irq_en_reg;
            rd_word[CTRL_ENABLE_BIT] = enable_reg;
         end
         STC_STATUS_OFS:
            rd_word[STAT_MATCH_BIT] = flag_reg;
         STC_PRE_LOW_OFS:
            rd_word = pre_low_reg;
         STC_PRE_HIGH_OFS:
            rd_word = {22'h000000, pre_ext_reg, pre_top_reg}; // [R2] [R14]
         STC_VAL_LOW_OFS:
            rd_word = base_reg[31:0]; // [R5] [R7]
         STC_VAL_HIGH_OFS:
            rd_word = {22'h000000, ext_reg, base_reg[STC_BASE_W-1]}; // [R8] [R9] [R14]
         STC_CMP_LOW_OFS:
            rd_word = cmp_low_reg; // [R11]
         STC_CMP_HIGH_OFS:
            rd_word = {31'h00000000, cmp_top_reg}; // [R12] [R14]
         STC_MSK_LOW_OFS:
            rd_word = msk_low_reg;
         STC_MSK_HIGH_OFS:
            rd_word = {31'h00000000, msk_top_reg};
         default:
            rd_hit = 1'b0;
      endcase
   end

   // read data and error captured in the setup cycle
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         prdata_reg  <= STC_WORD_RST;
         pslverr_reg <= 1'b0;
      end
      else if (rd_setup)
      begin
         prdata_reg  <= pwrite ? STC_WORD_RST : rd_word;
         pslverr_reg <= ~rd_hit;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_preload_arms: assert property ( // [R1]
      wr_access && (paddr == STC_PRE_HIGH_OFS || paddr == STC_PRE_LOW_OFS) |=> load_pend_reg)
      else $error("preload write did not arm the counter load");

   a_preload_loads: assert property ( // [R20]
      load_pend_reg |=> base_reg == {$past(pre_top_reg), $past(pre_low_reg)} && ext_reg == $past(pre_ext_reg))
      else $error("counter did not take the preload value");

   a_hold_disabled: assert property ( // [R18]
      !enable_reg && !load_pend_reg |=> $stable(base_reg) && $stable(ext_reg))
      else $error("counter moved while time clock disabled");

   a_ext_wraps: assert property ( // [R16]
      advance && !load_pend_reg && ext_reg == STC_EXT_LAST |=> ext_reg == 9'h000
         && base_reg == $past(base_reg) + 33'h0_0000_0001)
      else $error("extension wrap did not step base");

   a_base_90k_holds: assert property ( // [R16]
      advance && !load_pend_reg && rate_reg == STC_RATE_90K && ext_reg < STC_EXT_LAST |=> $stable(base_reg))
      else $error("base stepped before extension wrap");

   a_match_sets: assert property ( // [R10]
      irq_en_reg && updated_reg && match |=> time_match_flag)
      else $error("enabled match did not set the flag");

   a_match_disabled: assert property ( // [R10]
      !irq_en_reg && !time_match_flag |=> !time_match_flag)
      else $error("flag rose with compare disabled");

   a_value_read: assert property ( // [R5]
      rd_setup && !pwrite && paddr == STC_VAL_LOW_OFS |=> penable |-> prdata == $past(base_reg[31:0]))
      else $error("value low read does not show base");

   a_high_zero: assert property ( // [R14]
      rd_setup && (paddr == STC_VAL_HIGH_OFS || paddr == STC_PRE_HIGH_OFS) ##1 penable
         |-> prdata[31:10] == 22'h000000)
      else $error("reserved high bits read nonzero");

   c_ext_wrap: cover property (advance && ext_reg == STC_EXT_LAST);
   c_flag_set: cover property (match_event);
   c_preload: cover property (load_pend_reg && advance);
   c_rate_tick: cover property (advance && rate_reg == STC_RATE_TICK);

endmodule
`default_nettype wire

// file: stc_pkg.sv
// stc_pkg: register map, field layout and reset values of the system time clock
package stc_pkg;

   // bus and counter geometry
   localparam int              STC_ADDR_W         = 8;
   localparam int              STC_DATA_W         = 32;
   localparam int              STC_BASE_W         = 33;
   localparam int              STC_EXT_W          = 9;

   // register byte offsets
   localparam logic [7:0]      STC_CTRL_OFS       = 8'h00;
   localparam logic [7:0]      STC_STATUS_OFS     = 8'h04;
   localparam logic [7:0]      STC_PRE_LOW_OFS    = 8'h08;
   localparam logic [7:0]      STC_PRE_HIGH_OFS   = 8'h0C;
   localparam logic [7:0]      STC_VAL_LOW_OFS    = 8'h10;
   localparam logic [7:0]      STC_VAL_HIGH_OFS   = 8'h14;
   localparam logic [7:0]      STC_CMP_LOW_OFS    = 8'h18;
   localparam logic [7:0]      STC_CMP_HIGH_OFS   = 8'h1C;
   localparam logic [7:0]      STC_MSK_LOW_OFS    = 8'h20;
   localparam logic [7:0]      STC_MSK_HIGH_OFS   = 8'h24;

   // control field positions
   localparam int              CTRL_RATE_BIT      = 2;
   localparam int              CTRL_IRQ_EN_BIT    = 3;
   localparam int              CTRL_ENABLE_BIT    = 5;
   // status field position
   localparam int              STAT_MATCH_BIT     = 0;
   // high-word field positions
   localparam int              HIGH_TOP_BIT       = 0;
   localparam int              HIGH_EXT_LSB       = 1;
   localparam int              HIGH_EXT_MSB       = 9;

   // reset values
   localparam logic [31:0]     STC_WORD_RST       = 32'h0000_0000;
   localparam logic [8:0]      STC_EXT_RST        = 9'h000;
   localparam logic [32:0]     STC_BASE_RST       = 33'h0_0000_0000;
   localparam logic            STC_BIT_RST        = 1'h0;

   // extension counts 0..299, then the base advances
   localparam logic [8:0]      STC_EXT_LAST       = 9'h12B;

   // counter rate select
   typedef enum logic
   {
      STC_RATE_90K  = 1'b0,
      STC_RATE_TICK = 1'b1
   } stc_rate_t;

endpackage

// file: stc_edge_sync.sv
// stc_edge_sync: two-flop synchroniser and rising-edge pulse for the time clock pin
`timescale 1ns/1ps
`default_nettype none
module stc_edge_sync (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,
   // asynchronous pin
   input  wire logic pin_in,
   // one-cycle pulse per rising edge of the pin
   output logic      rise_pulse
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // meta_reg feeds only sync_reg
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign rise_pulse = sync_reg & ~last_reg;

endmodule
`default_nettype wire

// file: stc_masked_match.sv
// stc_masked_match: masked equality of the running base against the compare time
`timescale 1ns/1ps
`default_nettype none
module stc_masked_match
   import stc_pkg::*;
(
   // operands
   input  wire logic [STC_BASE_W-1:0] count_base,
   input  wire logic [STC_BASE_W-1:0] compare_time,
   input  wire logic [STC_BASE_W-1:0] compare_mask,
   // result
   output logic                       match
);

   // a set mask bit drops that bit out of the test
   assign match = ~|((count_base ^ compare_time) & ~compare_mask); // [R15]

endmodule
`default_nettype wire

// file: test_ts_system_time_clock.sv
// test_ts_system_time_clock: self-checking bench for the system time clock block
`timescale 1ns/1ps
`default_nettype none
module test_ts_system_time_clock
   import stc_pkg::*;
;
   logic        ref_clk;
   logic        reset;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        time_clock_input;
   logic        time_match_flag;
   logic [31:0] last_rd;
   logic        last_err;
   int          error_cnt;
   int          comparisons;

   stc_timer u_stc_timer (
      .ref_clk          (ref_clk),
      .reset            (reset),
      .paddr            (paddr),
      .psel             (psel),
      .penable          (penable),
      .pwrite           (pwrite),
      .pwdata           (pwdata),
      .pstrb            (pstrb),
      .prdata           (prdata),
      .pready           (pready),
      .pslverr          (pslverr),
      .time_clock_input (time_clock_input),
      .time_match_flag  (time_match_flag)
   );

   always #25 ref_clk = ~ref_clk;

   task automatic report_and_stop;
      $display("counts: comparisons=%0d errors=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one apb transfer; the master never assumes the slave's latency
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      // only the watchdog ends a wait that never sees pready
      while (pready !== 1'b1)
      begin
         @(posedge ref_clk);
      end
      last_rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next setup never reassigns in this time step
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // pin edge needs three ref_clk edges to reach the counter
   task automatic tick;
      time_clock_input <= 1'b1;
      repeat (2) @(posedge ref_clk);
      time_clock_input <= 1'b0;
      repeat (5) @(posedge ref_clk);
   endtask

   task automatic test_reset_and_fields;
      chk({31'h0, pready}, 32'h0000_0001);
      rd(STC_PRE_HIGH_OFS);
      chk(last_rd, 32'h0000_0000);
      rd(STC_VAL_LOW_OFS);
      chk(last_rd, 32'h0000_0000);
      rd(STC_VAL_HIGH_OFS);
      chk(last_rd, 32'h0000_0000);
      rd(STC_CMP_LOW_OFS);
      chk(last_rd, 32'h0000_0000);
      rd(STC_CMP_HIGH_OFS);
      chk(last_rd, 32'h0000_0000);
      wr(STC_CMP_LOW_OFS, 32'hA5A5_5A5A);
      rd(STC_CMP_LOW_OFS);
      chk(last_rd, 32'hA5A5_5A5A);
      wr(STC_CMP_HIGH_OFS, 32'hFFFF_FFFF);
      rd(STC_CMP_HIGH_OFS);
      chk(last_rd, 32'h0000_0001);
      wr(8'h40, 32'hFFFF_FFFF);
      chk({31'h0, last_err}, 32'h0000_0001);
      rd(8'h40);
      chk({last_err, last_rd[30:0]}, 32'h8000_0000);
      $display("test reset_and_fields done");
   endtask

   task automatic test_preload_and_count;
      wr(STC_CTRL_OFS, 32'h0000_0000);
      wr(STC_PRE_LOW_OFS, 32'hFFFF_FFFF);
      wr(STC_PRE_HIGH_OFS, 32'hFFFF_FFFF);
      rd(STC_PRE_HIGH_OFS);
      chk(last_rd, 32'h0000_03FF);
      rd(STC_VAL_HIGH_OFS);
      chk(last_rd, 32'h0000_03FF);
      rd(STC_VAL_LOW_OFS);
      chk(last_rd, 32'hFFFF_FFFF);
      // extension 298, base top 0: a discontinuity reload
      wr(STC_PRE_HIGH_OFS, 32'h0000_0254);
      tick();
      rd(STC_VAL_HIGH_OFS);
      chk(last_rd, 32'h0000_0254);
      rd(STC_VAL_LOW_OFS);
      chk(last_rd, 32'hFFFF_FFFF);
      wr(STC_CTRL_OFS, 32'h0000_0020);
      tick();
      rd(STC_VAL_HIGH_OFS);
      chk(last_rd, 32'h0000_0256);
      tick();
      rd(STC_VAL_LOW_OFS);
      chk(last_rd, 32'h0000_0000);
      rd(STC_VAL_HIGH_OFS);
      chk(last_rd, 32'h0000_0001);
      $display("test preload_and_count done");
   endtask

   task automatic test_tick_mode;
      wr(STC_CTRL_OFS, 32'h0000_0000);
      wr(STC_PRE_LOW_OFS, 32'h0000_0005);
      wr(STC_PRE_HIGH_OFS, 32'h0000_0000);
      wr(STC_CTRL_OFS, 32'h0000_0024);
      tick();
      tick();
      rd(STC_VAL_LOW_OFS);
      chk(last_rd, 32'h0000_0007);
      // second back-to-back read; pin idle, so both agree
      rd(STC_VAL_LOW_OFS);
      chk(last_rd, 32'h0000_0007);
      rd(STC_VAL_HIGH_OFS);
      chk(last_rd, 32'h0000_0004);
      wr(STC_VAL_LOW_OFS, 32'h0000_0000);
      rd(STC_VAL_LOW_OFS);
      chk(last_rd, 32'h0000_0007);
      $display("test tick_mode done");
   endtask

   task automatic test_compare;
      wr(STC_CTRL_OFS, 32'h0000_0000);
      wr(STC_PRE_LOW_OFS, 32'h0000_0010);
      wr(STC_PRE_HIGH_OFS, 32'h0000_0256);
      wr(STC_CMP_LOW_OFS, 32'h0000_0011);
      wr(STC_CMP_HIGH_OFS, 32'h0000_0000);
      wr(STC_MSK_LOW_OFS, 32'h0000_0000);
      wr(STC_MSK_HIGH_OFS, 32'h0000_0000);
      wr(STC_CTRL_OFS, 32'h0000_0028);
      chk({31'h0, time_match_flag}, 32'h0000_0000);
      tick();
      chk({31'h0, time_match_flag}, 32'h0000_0001);
      rd(STC_STATUS_OFS);
      chk(last_rd, 32'h0000_0001);
      wr(STC_STATUS_OFS, 32'h0000_0001);
      chk({31'h0, time_match_flag}, 32'h0000_0000);
      // base stays 0x11 while the extension steps; bit 1 differs
      wr(STC_CTRL_OFS, 32'h0000_0020);
      wr(STC_CMP_LOW_OFS, 32'h0000_0013);
      wr(STC_CTRL_OFS, 32'h0000_0028);
      tick();
      chk({31'h0, time_match_flag}, 32'h0000_0000);
      wr(STC_CTRL_OFS, 32'h0000_0020);
      wr(STC_MSK_LOW_OFS, 32'h0000_0002);
      tick();
      chk({31'h0, time_match_flag}, 32'h0000_0000);
      wr(STC_CTRL_OFS, 32'h0000_0028);
      tick();
      chk({31'h0, time_match_flag}, 32'h0000_0001);
      $display("test compare done");
   endtask

   initial
   begin
      ref_clk = 1'b0;
      reset = 1'b1;
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0000_0000;
      pstrb = 4'hF;
      time_clock_input = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      test_reset_and_fields();
      test_preload_and_count();
      test_tick_mode();
      test_compare();
      report_and_stop();
   end

   // watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      error_cnt++;
      report_and_stop();
   end
endmodule
`default_nettype wire
